// *** rtl/mrv_pkg.sv ***
package mrv_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETUP_TIME_NS = 300;
    // least time: round up to whole cycles, at least one
    localparam int SETUP_CYCLES_RAW =
        (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYCLES = (SETUP_CYCLES_RAW < 1) ? 1 : SETUP_CYCLES_RAW;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------------
    // data and mark
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int REV_W  = 2;
    localparam logic [7:0] USER_MARK  = 8'h99;
    localparam logic [7:0] BLANK_BYTE = 8'hff;

    // ------------------------------------------------------------------
    // apb map of the controller
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR   = 8'h00; // [1:0] rev, [2] start, [3] ce_save
    localparam logic [7:0] STATUS_ADDR = 8'h04; // [0] busy [1] valid [2] fail
    localparam logic [7:0] DATA_ADDR   = 8'h08; // sampled byte
    localparam logic [7:0] PROG_ADDR   = 8'h0c; // not decoded by the controller: access gives pslverr, reads 0
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_CESAVE_BIT = 3;

    // ------------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        MRV_IDLE     = 7'h01,
        MRV_SELECT   = 7'h02,
        MRV_STROBE   = 7'h04,
        MRV_CHECK    = 7'h08,
        MRV_RESELECT = 7'h10,
        MRV_RECONFIG = 7'h20,
        MRV_HALT     = 7'h40
    } mrv_state_type;
endpackage

// *** rtl/mrv_link_if.sv ***
`timescale 1ns/10ps
interface mrv_link_if;
    import mrv_pkg::*;
    logic [REV_W-1:0]  rev_sel;
    logic              revision_sample_strobe;
    logic              oe_reset;
    logic              chip_enable_n;
    logic [DATA_W-1:0] data;
    // init indicator is open drain: the controller drives high only
    logic              init_out;
    logic              init_oe;

    modport ctrl (
        output rev_sel, revision_sample_strobe, oe_reset, chip_enable_n,
        output init_out, init_oe,
        input  data
    );
    modport prom (
        input  rev_sel, revision_sample_strobe, oe_reset, chip_enable_n,
        output data
    );
endinterface

// *** rtl/mrv_sync2.sv ***
`timescale 1ns/10ps
module mrv_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// *** rtl/mrv_prom.sv ***
`timescale 1ns/10ps
module mrv_prom #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // program image load, one revision per write
    input  wire logic                  prog_we,
    input  wire logic [mrv_pkg::REV_W-1:0]  prog_rev,
    input  wire logic [mrv_pkg::DATA_W-1:0] prog_byte,
    input  wire logic                  prog_done,
    // standby indication
    output logic                       standby,
    // link
    mrv_link_if.prom                   link
);
    import mrv_pkg::*;

    logic [DATA_W-1:0] first_byte_mem [DEPTH];
    logic [DEPTH-1:0]  program_complete_flag;
    logic [REV_W-1:0]  rev_latched_reg;
    logic              strobe_q_reg;
    logic [DATA_W-1:0] data_reg;

    // image store; partial programming clears the completion flag
    always_ff @(posedge clk) begin
        if (srst) begin
            program_complete_flag <= '0;
        end else if (prog_we) begin
            first_byte_mem[prog_rev]        <= prog_byte;
            program_complete_flag[prog_rev] <= prog_done;
        end
    end

    // revision captured on strobe rising edge
    always_ff @(posedge clk) begin
        if (srst) begin
            strobe_q_reg    <= 1'b0;
            rev_latched_reg <= '0;
        end else begin
            strobe_q_reg <= link.revision_sample_strobe;
            if (link.revision_sample_strobe && !strobe_q_reg) begin
                rev_latched_reg <= link.rev_sel;
            end
        end
    end

    // output stage: blank unless enabled, out of reset and complete
    always_ff @(posedge clk) begin
        if (srst) begin
            data_reg <= BLANK_BYTE;
        end else if (link.chip_enable_n || !link.oe_reset) begin
            data_reg <= BLANK_BYTE;
        end else if (program_complete_flag[rev_latched_reg]) begin
            data_reg <= first_byte_mem[rev_latched_reg];
        end else begin
            data_reg <= BLANK_BYTE;
        end
    end

    assign link.data = data_reg;
    assign standby   = link.chip_enable_n;
endmodule

// *** rtl/mrv_ctrl.sv ***
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
// Operation
// - prom hides data until revision complete
// - blank revision reads all ones
// - set revision, then strobe rising edge
// - raise oe/reset, prom shows first byte
// - wait 300 ns before sampling data
// - byte 99 means revision valid
// - other byte: no reconfig, user decides
// - check occurs before any reconfiguration
// - image first byte changed ff to 99
// - line checksum recomputed as two's complement
// - driving init high leaves pin usable
// - chip enable high gives standby
// - drive chip enable low when needed
// - optionally deassert chip enable when idle
// - only mark checked, no deeper verify
// - optional sync word search, not built
// - revision select stable 300 ns first
// - prom captures select on strobe rise
// - reconfig request low 300 ns
// - failed check halts until reset
module mrv_ctrl (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // reconfiguration request to the fpga core
    output logic             reconfig_request_n,
    // link
    mrv_link_if.ctrl         link
);
    import mrv_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    mrv_state_type     state_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic [REV_W-1:0]  rev_reg;
    logic              ce_save_reg;
    logic              start_reg;
    logic              valid_reg;
    logic              fail_reg;
    logic [DATA_W-1:0] sample_reg;
    logic [DATA_W-1:0] data_sync;
    logic              wr_en;
    logic              rd_en;
    logic              cnt_done;

    // prom data comes from another chip, so synchronise it
    mrv_sync2 #(.W(DATA_W)) mrv_sync2_i (
        .clk  (clk),
        .srst (srst),
        .d    (link.data),
        .q    (data_sync)
    );

    // ------------------------------------------------------------------
    // apb slave, zero wait state
    // ------------------------------------------------------------------
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    assign pslverr = psel && penable && (paddr != CTRL_ADDR) &&
                     (paddr != STATUS_ADDR) && (paddr != DATA_ADDR);

    // control register; start is a pulse accepted only while idle
    always_ff @(posedge clk) begin
        if (srst) begin
            rev_reg     <= '0;
            ce_save_reg <= 1'b0;
            start_reg   <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (wr_en && paddr == CTRL_ADDR) begin
                rev_reg     <= pwdata[REV_W-1:0];
                ce_save_reg <= pwdata[CTRL_CESAVE_BIT];
                start_reg   <= pwdata[CTRL_START_BIT];
            end
        end
    end

    // read data registered in setup cycle, valid in access phase
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= '0;
        end else if (rd_en && !penable) begin
            unique case (paddr)
                CTRL_ADDR:   prdata <= {28'h0000000, ce_save_reg, 1'b0,
                                        rev_reg};
                STATUS_ADDR: prdata <= {29'h00000000, fail_reg, valid_reg,
                                        state_reg != MRV_IDLE};
                DATA_ADDR:   prdata <= {24'h000000, sample_reg};
                default:     prdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // wait counter: 300 ns rounded up to clock cycles
    // ------------------------------------------------------------------
    // two extra cycles cover the data synchroniser latency
    assign cnt_done = (cnt_reg == CNT_W'(SETUP_CYCLES + 1));

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
        end else if (state_reg == MRV_IDLE || state_reg == MRV_HALT ||
                     state_reg == MRV_CHECK || cnt_done) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg  <= MRV_IDLE;
            valid_reg  <= 1'b0;
            fail_reg   <= 1'b0;
            sample_reg <= BLANK_BYTE;
        end else begin
            unique case (state_reg)
                MRV_IDLE: begin
                    if (start_reg) begin
                        state_reg <= MRV_SELECT;
                        valid_reg <= 1'b0;
                    end
                end
                MRV_SELECT: begin
                    if (cnt_done) state_reg <= MRV_STROBE;
                end
                MRV_STROBE: begin
                    if (cnt_done) state_reg <= MRV_CHECK;
                end
                MRV_CHECK: begin
                    // one byte only: no sync word search
                    sample_reg <= data_sync;
                    if (data_sync == USER_MARK) begin
                        valid_reg <= 1'b1;
                        state_reg <= MRV_RESELECT;
                    end else begin
                        fail_reg  <= 1'b1;
                        state_reg <= MRV_HALT;
                    end
                end
                MRV_RESELECT: begin
                    if (cnt_done) state_reg <= MRV_RECONFIG;
                end
                MRV_RECONFIG: begin
                    // the fpga is erased here; if not, go back to idle
                    if (cnt_done) state_reg <= MRV_IDLE;
                end
                MRV_HALT: begin
                    state_reg <= MRV_HALT;
                end
                default: state_reg <= MRV_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // link outputs, all registered
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            link.rev_sel                <= '0;
            link.revision_sample_strobe <= 1'b0;
            link.oe_reset               <= 1'b0;
            link.chip_enable_n          <= 1'b0;
            link.init_out               <= 1'b0;
            link.init_oe                <= 1'b0;
            reconfig_request_n          <= 1'b1;
        end else begin
            // select follows the register only while idle, so a write
            // during a sequence cannot move it under the strobe
            if (state_reg == MRV_IDLE) begin
                link.rev_sel <= rev_reg;
            end
            link.revision_sample_strobe <= (state_reg == MRV_STROBE) ||
                                           (state_reg == MRV_CHECK) ||
                                           (state_reg == MRV_RECONFIG);
            // oe/reset low in select phases so the prom resamples once
            link.oe_reset <= (state_reg == MRV_STROBE) ||
                             (state_reg == MRV_CHECK) ||
                             (state_reg == MRV_RECONFIG);
            // only drive init while raising it; release otherwise
            link.init_out <= 1'b1;
            link.init_oe  <= (state_reg == MRV_STROBE) ||
                             (state_reg == MRV_CHECK);
            // power save: enable only while a sequence runs
            link.chip_enable_n <= ce_save_reg &&
                                  (state_reg == MRV_IDLE ||
                                   state_reg == MRV_HALT);
            reconfig_request_n <= !(state_reg == MRV_RECONFIG);
        end
    end
endmodule

// *** testbench/mrv_link_properties.sv ***
`timescale 1ns/10ps
// ----------------------------------------------
// link checker
// ----------------------------------------------
module mrv_link_properties (
    // clock and reset
    input wire logic                      clk,
    input wire logic                      srst,
    // link and request
    input wire logic [mrv_pkg::REV_W-1:0] rev_sel,
    input wire logic                      revision_sample_strobe,
    input wire logic                      oe_reset,
    input wire logic                      chip_enable_n,
    input wire logic                      init_out,
    input wire logic                      init_oe,
    input wire logic                      reconfig_request_n
);
    import mrv_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // select must settle 300 ns before the prom samples it
    a_sel_setup: assert property (
        $rose(revision_sample_strobe) |-> $past(rev_sel, 6) == rev_sel)
        else $error("select moved within setup");
    a_sel_held: assert property (
        revision_sample_strobe |-> $stable(rev_sel))
        else $error("select moved while strobed");
    a_oe_strobe: assert property (
        $rose(oe_reset) |-> revision_sample_strobe)
        else $error("enable raised without strobe");
    // a short enable would sample the bus before data is valid
    a_oe_setup: assert property (
        $fell(oe_reset) |-> $past(oe_reset, 6))
        else $error("enable dropped before 300 ns");
    a_init_high: assert property (
        init_oe |-> (init_out && oe_reset))
        else $error("init driven low or apart from enable");
    a_ce_active: assert property (
        (revision_sample_strobe || oe_reset) |-> !chip_enable_n)
        else $error("prom disabled while in use");
    a_req_width: assert property (
        $fell(reconfig_request_n) |-> !reconfig_request_n [*6])
        else $error("request pulse short");
    a_req_strobe: assert property (
        !reconfig_request_n |-> revision_sample_strobe)
        else $error("request without strobe");
    c_req: cover property ($fell(reconfig_request_n));
    c_oe: cover property ($fell(oe_reset));
    c_save: cover property ($rose(chip_enable_n));
endmodule

// *** testbench/mrv_tb_top.sv ***
`timescale 1ns/10ps
// ----------------------------------------------
// bench top
// ----------------------------------------------
module mrv_tb_top;
    import mrv_pkg::*;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr;
    logic        req_n, prog_we, prog_done, standby, re;
    logic [7:0]  paddr, prog_byte;
    logic [1:0]  prog_rev;
    logic [31:0] pwdata, prdata, rq;
    int          fails, n_tests, cyc, low_cnt;

    mrv_link_if mrv_link_if_i ();
    mrv_ctrl mrv_ctrl_i (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reconfig_request_n(req_n),
        .link(mrv_link_if_i));
    mrv_prom mrv_prom_i (.clk(clk), .srst(srst), .prog_we(prog_we),
        .prog_rev(prog_rev), .prog_byte(prog_byte),
        .prog_done(prog_done), .standby(standby), .link(mrv_link_if_i));
    mrv_link_properties mrv_link_properties_i (.clk(clk), .srst(srst),
        .rev_sel(mrv_link_if_i.rev_sel),
        .revision_sample_strobe(mrv_link_if_i.revision_sample_strobe),
        .oe_reset(mrv_link_if_i.oe_reset),
        .chip_enable_n(mrv_link_if_i.chip_enable_n),
        .init_out(mrv_link_if_i.init_out),
        .init_oe(mrv_link_if_i.init_oe), .reconfig_request_n(req_n));

    // clock, timeout and request pulse width
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (!req_n) low_cnt++;
        if (cyc == 20000) begin
            fails++;
            stop_test;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task rst;
        low_cnt = 0;
        srst <= 1;
        repeat (5) @(posedge clk);
        srst <= 0;
        @(posedge clk);
    endtask

    // one apb transfer; pready, read data and error taken at one edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rq = prdata;
        re = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task prog(input logic [1:0] r, input logic [7:0] b, input logic dn);
        @(posedge clk);
        prog_we <= 1;
        prog_rev <= r;
        prog_byte <= b;
        prog_done <= dn;
        @(posedge clk);
        prog_we <= 0;
    endtask

    // start a check and poll until it has settled
    task run(input logic [1:0] r, input logic ce);
        int n;
        apb(1, CTRL_ADDR, {28'h0, ce, 1'b1, r});
        n = 0;
        // settled: failed (halted stays busy), or valid and back to idle
        do begin
            apb(0, STATUS_ADDR, 32'h0);
            n++;
        end while (!(rq[2] === 1'b1 || (rq[1] === 1'b1 && rq[0] === 1'b0))
                   && n < 100);
        chk(n < 100, 1);
    endtask

    task t_check(input logic [1:0] r, input logic [7:0] b, input logic dn,
                 input logic ce);
        logic ok;
        ok = (b == USER_MARK) && dn;
        rst;
        if (b != BLANK_BYTE) prog(r, b, dn);
        run(r, ce);
        chk(rq[2:1], ok ? 2'b01 : 2'b10);
        apb(0, DATA_ADDR, 32'h0);
        chk(rq[7:0], dn ? b : BLANK_BYTE);
        chk(ok ? low_cnt > 5 : low_cnt == 0, 1);
        $display("check rev %0d byte %h ended", r, b);
    endtask

    task t_reset;
        rst;
        chk(req_n, 1);
        chk(mrv_link_if_i.chip_enable_n, 0);
        apb(0, STATUS_ADDR, 32'h0);
        chk(rq, 0);
        $display("reset test ended");
    endtask

    // a failed revision stays halted, a second start changes nothing
    task t_halt;
        t_check(2'h1, BLANK_BYTE, 0, 0);
        apb(1, CTRL_ADDR, 32'h5);
        repeat (40) @(posedge clk);
        apb(0, STATUS_ADDR, 32'h0);
        chk(rq[2:1], 2'b10);
        chk(low_cnt, 0);
        $display("halt test ended");
    endtask

    task t_cesave;
        t_check(2'h3, USER_MARK, 1, 1);
        @(negedge clk);
        chk(mrv_link_if_i.chip_enable_n, 1);
        chk(standby, 1);
        $display("power save test ended");
    endtask

    task t_unmapped;
        apb(0, 8'h10, 32'h0);
        chk(re, 1);
        chk(rq, 0);
        $display("unmapped test ended");
    endtask

    initial begin
        {srst, psel, penable, pwrite, prog_we, prog_done} = 6'h20;
        {paddr, prog_byte, prog_rev, pwdata} = '0;
        {fails, n_tests, cyc, low_cnt} = '0;
        t_reset;
        t_halt;
        t_check(2'h2, USER_MARK, 0, 0);
        t_check(2'h0, 8'h5a, 1, 0);
        for (int i = 0; i < 4; i++) begin
            t_check(i[1:0], USER_MARK, 1, 0);
        end
        t_cesave;
        t_unmapped;
        stop_test;
    end
endmodule
